/* core/vsmc_pkg.sv */
/*
 Constants, state types and register map of the output-voltage setpoint
 and converter mode control block.
 Assumes a single 250 MHz clock and a serial control bus slave.
*/
package vsmc_pkg;
    // Register addresses on the serial control bus
    localparam logic [4:0] ADDR_COARSE    = 5'h00;
    localparam logic [4:0] ADDR_CONFIG    = 5'h01;
    localparam logic [4:0] ADDR_FINE      = 5'h03;
    // Converter configuration fields
    localparam int         CFG_AUTO_PFM   = 5;
    localparam int         CFG_BYPASS     = 4;
    localparam logic [7:0] CONFIG_RST     = 8'h00;
    localparam logic [7:0] SETPOINT_RST   = 8'h00;
    // Setpoint upper seven bits that select special states
    localparam logic [6:0] SP_BYPASS      = 7'h7f;
    localparam logic [6:0] SP_LOW_POWER   = 7'h00;
    localparam logic [6:0] SP_STANDBY     = 7'h02;
    // Command codes in the command byte
    localparam logic [2:0] CMD_WRITE      = 3'h2;
    localparam logic [2:0] CMD_READ       = 3'h3;
    // Bit counts within a frame
    localparam logic [3:0] CMD_LAST       = 4'hc;
    localparam logic [3:0] DATA_LAST      = 4'h8;
    localparam logic [3:0] RD_FIRST       = 4'h1;
    localparam logic [3:0] RD_LAST        = 4'h9;
    localparam logic [3:0] RD_PARK        = 4'ha;
    localparam logic [3:0] RD_END         = 4'hb;
    // Timing
    localparam int         CLK_MHZ        = 250;
    localparam int         T_SETUP_NS     = 50;
    localparam int         SETUP_CYC      = T_SETUP_NS * CLK_MHZ / 1000;
    localparam int         T_IO_RESET_US  = 10;
    localparam logic [1:0] SYNC_FILL      = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_WDATA, ST_RDATA, ST_PARK
    } vsmc_state_t;

    typedef enum logic [1:0] {
        PS_LOW_POWER, PS_STANDBY, PS_ACTIVE
    } vsmc_pstate_t;
endpackage

/* core/vsmc_sync.sv */
/*
 Three-stage synchroniser for pin inputs, one chain per bit.
 Assumes the inputs are asynchronous to clk; stage one feeds only stage two.
*/
`timescale 1ns/1ps
module vsmc_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] s2_o,
    output logic      [W-1:0] s3_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= d_i[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
        end
    endgenerate

    assign s2_o = s2_q;
    assign s3_o = s3_q;
endmodule

/* core/vsmc_top.sv */
/*
 Control logic of the step-down converter: serial bus slave, shared
 setpoint behind coarse and fine views, mode and power-state outputs.
 Assumes rst is held while the I/O supply is absent and clk runs at 250 MHz.
*/
// Notes on behaviour
// - Fine register write loads all eight setpoint bits.
// - Coarse write loads upper seven setpoint bits and clears the LSB.
// - Coarse and fine views read and write the same stored setpoint.
// - Fine readback after a coarse write shows LSB zero.
// - Config bit 5 low selects forced PWM only.
// - Config bit 5 high selects automatic PFM/PWM transitions.
// - Bypass when config bit 4 set or setpoint upper bits all ones.
// - Low-power, standby, active states; converter runs only when active.
// - Bus interface live within 50 ns of supply rising.
// - PWM/PFM output target follows the setpoint register.
// - Shutdown whenever the I/O supply is off, logic held in reset.
// - Start in low-power state with converter disabled.
// - Modulation-mode bit resets to zero, forced PWM.
`timescale 1ns/1ps
module vsmc_top #(
    parameter logic [3:0] SLAVE_ID = 4'h5  // Arbitrary value
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   sclk_i,
    input  wire logic                   sdata_i,
    output logic                        sdata_o,
    output logic                        sdata_oe,
    output logic [7:0]                  vout_target,
    output logic                        mode_auto_pfm,
    output logic                        forced_bypass,
    output logic                        converter_en,
    output vsmc_pkg::vsmc_pstate_t      power_state,
    output logic                        bus_ready
);
    import vsmc_pkg::*;

    logic [1:0]   s2;
    logic [1:0]   s3;
    logic [1:0]   lvl_q;
    logic [1:0]   lvl_d;
    logic [1:0]   prev_q;
    logic [1:0]   rdy_cnt_q;
    vsmc_state_t  st_q;
    logic [11:0]  sh_q;
    logic [3:0]   cnt_q;
    logic [4:0]   addr_q;
    logic [8:0]   rdsh_q;
    logic [7:0]   setpoint_q;
    logic [7:0]   setpoint_d;
    logic [7:0]   config_q;
    logic [7:0]   config_d;
    vsmc_pstate_t pstate_d;

    vsmc_sync #(.W(2)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .d_i  ({sdata_i, sclk_i}),
        .s2_o (s2),
        .s3_o (s3)
    );

    // A pin level changes only once stages two and three agree
    assign lvl_d = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl_q);

    wire sclk  = lvl_q[0];
    wire sdata = lvl_q[1];
    wire fall  = prev_q[0] & ~sclk;
    wire rise  = ~prev_q[0] & sclk;
    // Start condition: data falls while the clock stays low
    wire ssc   = bus_ready & ~sdata_oe & ~sclk & ~prev_q[0]
               & prev_q[1] & ~sdata;

    wire [12:0] cmd_word  = {sh_q, sdata};
    wire [8:0]  data_word = {sh_q[7:0], sdata};
    wire        cmd_done  = fall & (st_q == ST_CMD) & (cnt_q == CMD_LAST);
    wire        data_done = fall & (st_q == ST_WDATA) & (cnt_q == DATA_LAST);
    wire        cmd_ok    = (cmd_word[12:9] == SLAVE_ID) & (^cmd_word);
    wire        data_ok   = ^data_word;
    wire        is_coarse = cmd_word[8];
    wire        is_write  = cmd_word[8:6] == CMD_WRITE;
    wire        is_read   = cmd_word[8:6] == CMD_READ;

    wire wr_coarse = cmd_done & cmd_ok & is_coarse;
    wire wr_data   = data_done & data_ok;
    wire wr_fine   = wr_data & (addr_q == ADDR_FINE);
    wire wr_config = wr_data & (addr_q == ADDR_CONFIG);

    // Both views decode onto one stored setpoint
    wire [7:0] rd_val = (addr_q == ADDR_COARSE) ? {1'b0, setpoint_q[7:1]} :
                        (addr_q == ADDR_CONFIG) ? config_q :
                        (addr_q == ADDR_FINE)   ? setpoint_q : 8'h00;

    assign setpoint_d = wr_fine   ? data_word[8:1] :
                        wr_coarse ? {cmd_word[7:1], 1'b0} :
                        setpoint_q;
    assign config_d   = wr_config ? data_word[8:1] : config_q;

    // Decoded from the stored setpoint so state and target move together
    assign pstate_d = (setpoint_q[7:1] == SP_LOW_POWER) ? PS_LOW_POWER :
                      (setpoint_q[7:1] == SP_STANDBY)   ? PS_STANDBY :
                      PS_ACTIVE;

    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q     <= 2'h0;
            prev_q    <= 2'h0;
            rdy_cnt_q <= 2'h0;
            bus_ready <= 1'b0;
        end else begin
            lvl_q  <= lvl_d;
            prev_q <= lvl_q;
            if (rdy_cnt_q != SYNC_FILL) begin
                rdy_cnt_q <= rdy_cnt_q + 2'h1;
            end
            bus_ready <= rdy_cnt_q == SYNC_FILL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            setpoint_q    <= SETPOINT_RST;
            config_q      <= CONFIG_RST;
            vout_target   <= SETPOINT_RST;
            mode_auto_pfm <= 1'b0;
            forced_bypass <= 1'b0;
            converter_en  <= 1'b0;
            power_state   <= PS_LOW_POWER;
        end else begin
            setpoint_q    <= setpoint_d;
            config_q      <= config_d;
            vout_target   <= setpoint_q;
            mode_auto_pfm <= config_q[CFG_AUTO_PFM];
            forced_bypass <= config_q[CFG_BYPASS]
                           | (setpoint_q[7:1] == SP_BYPASS);
            power_state   <= pstate_d;
            converter_en  <= pstate_d == PS_ACTIVE;
        end
    end

    // Frame sequencer; a new start condition restarts the frame, except while sdata_oe is high
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q     <= ST_IDLE;
            sh_q     <= 12'h000;
            cnt_q    <= 4'h0;
            addr_q   <= 5'h00;
            rdsh_q   <= 9'h000;
            sdata_o  <= 1'b0;
            sdata_oe <= 1'b0;
        end else if (ssc) begin
            st_q  <= ST_CMD;
            cnt_q <= 4'h0;
        end else begin
            case (st_q)
                ST_CMD: begin
                    if (fall) begin
                        sh_q  <= cmd_word[11:0];
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (cmd_done) begin
                        cnt_q  <= 4'h0;
                        addr_q <= cmd_word[5:1];
                        if (!cmd_ok) begin
                            st_q <= ST_IDLE;
                        end else if (is_coarse) begin
                            st_q <= ST_PARK;
                        end else if (is_write) begin
                            st_q <= ST_WDATA;
                        end else if (is_read) begin
                            st_q <= ST_RDATA;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_WDATA: begin
                    if (fall) begin
                        sh_q  <= cmd_word[11:0];
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (data_done) begin
                        st_q <= ST_PARK;
                    end
                end
                ST_RDATA: begin
                    if (rise) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h0) begin
                            rdsh_q <= {rd_val, ~^rd_val};
                        end else if (cnt_q <= RD_LAST) begin
                            sdata_o  <= rdsh_q[8];
                            sdata_oe <= 1'b1;
                            rdsh_q   <= {rdsh_q[7:0], 1'b0};
                        end else if (cnt_q == RD_PARK) begin
                            sdata_o <= 1'b0;
                        end
                    end
                    if (fall && cnt_q == RD_END) begin
                        sdata_oe <= 1'b0;
                        st_q     <= ST_IDLE;
                    end
                end
                ST_PARK: begin
                    if (fall) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Plain constant of this file so the delay bound needs no package name
    localparam int LIVE_CYC = SETUP_CYC;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_fine_load: assert property (
        wr_fine |=> setpoint_q == $past(data_word[8:1]))
        else $error("fine write did not load setpoint");
    a_coarse_load: assert property (
        wr_coarse && !wr_fine |=> setpoint_q[7:1] == $past(cmd_word[7:1]))
        else $error("coarse write did not load upper bits");
    a_coarse_lsb: assert property (
        wr_coarse && !wr_fine |=> setpoint_q[0] == 1'b0 ##1
        vout_target[0] == 1'b0)
        else $error("coarse write left setpoint lsb set");
    a_view_alias: assert property (
        st_q == ST_RDATA && rise && cnt_q == 4'h0
        && addr_q == ADDR_COARSE
        |=> rdsh_q[8:1] == {1'b0, setpoint_q[7:1]})
        else $error("coarse view disagrees with setpoint");
    a_pwm_mode: assert property (
        !config_q[CFG_AUTO_PFM] |=> !mode_auto_pfm)
        else $error("auto mode without config bit");
    a_auto_mode: assert property (
        wr_config && data_word[CFG_AUTO_PFM + 1] |=> ##1 mode_auto_pfm)
        else $error("auto mode not entered");
    a_bypass_sel: assert property (
        setpoint_q[7:1] == SP_BYPASS |=> forced_bypass)
        else $error("bypass not forced by setpoint");
    a_active_only: assert property (
        converter_en |-> power_state == PS_ACTIVE
        && vout_target[7:1] != SP_STANDBY)
        else $error("converter on outside active state");
    a_bus_live: assert property (
        $fell(rst) |-> ##[1:LIVE_CYC] bus_ready)
        else $error("bus not live in time");
    a_reset_state: assert property (
        $fell(rst) |-> !converter_en && power_state == PS_LOW_POWER
        && !mode_auto_pfm)
        else $error("wrong state after reset");
endmodule

/* tb/vsmc_master.sv */
/*
 Behavioural serial control bus master that drives the setpoint block.
 Assumes clk is the block clock; every bus edge is launched on its falling
 edge, and sid is set by the bench before the first frame.
*/
`timescale 1ns/1ps
module vsmc_master #(
    parameter int H = 10
) (
    input  wire logic clk,
    input  wire logic sdata_o,
    input  wire logic sdata_oe,
    output logic      sclk,
    output logic      sdata
);
    logic       m_d;
    logic       m_oe;
    logic [3:0] sid;
    // No keeper on the line: an undriven line shows the inverse of m_d
    assign sdata = sdata_oe ? sdata_o : (m_oe ? m_d : ~m_d);
    initial begin
        sclk = 1'b0;
        m_d  = 1'b0;
        m_oe = 1'b1;
    end
    task automatic hw();
        repeat (H) @(negedge clk);
    endtask
    task automatic clk_bit(input logic b);
        m_d  = b;
        sclk = 1'b1;
        hw();
        sclk = 1'b0;
        hw();
    endtask
    // Start pulse, slave id, command and odd parity
    task automatic cmd_frame(input logic [7:0] cmd);
        logic [11:0] f;
        f   = {sid, cmd};
        m_d = 1'b1;
        hw();
        m_d = 1'b0;
        hw();
        for (int i = 11; i >= 0; i--) clk_bit(f[i]);
        clk_bit(~^f);
    endtask
    task automatic write(input logic [4:0] a, input logic [7:0] d);
        cmd_frame({3'h2, a});
        for (int i = 7; i >= 0; i--) clk_bit(d[i]);
        clk_bit(~^d);
        clk_bit(1'b0);
    endtask
    task automatic coarse(input logic [6:0] d);
        cmd_frame({1'b1, d});
        clk_bit(1'b0);
    endtask
    task automatic read(input logic [4:0] a, output logic [8:0] q);
        cmd_frame({3'h3, a});
        m_oe = 1'b0;
        clk_bit(1'b1);
        for (int i = 0; i < 9; i++) begin
            sclk = 1'b1;
            hw();
            q    = {q[7:0], sdata};
            sclk = 1'b0;
            hw();
        end
        clk_bit(1'b1);
        m_d  = 1'b0;
        m_oe = 1'b1;
        // Let the line settle before a following start pulse
        hw();
    endtask
endmodule

/* tb/vout_setpoint_mode_control_bench.sv */
/*
 Self-checking bench for the setpoint and mode control block.
 Assumes vsmc_master as the bus partner and a 250 MHz block clock.
*/
`timescale 1ns/1ps
module vout_setpoint_mode_control_bench;
    import vsmc_pkg::*;
    localparam logic [3:0] SID = 4'h5;  // Arbitrary slave address
    logic         clk, rst, sclk, sdata, sdata_o, sdata_oe;
    logic         mode_auto_pfm, forced_bypass, converter_en, bus_ready;
    logic [7:0]   vout_target;
    vsmc_pstate_t power_state;
    int           n_errors;
    int           checks_done;
    logic [8:0]   q;
    // Rows: kind (0 fine, 1 coarse, 2 config), data, setpoint, config
    logic [31:0]  rows [13] = '{32'h00404000, 32'h0155aa00, 32'h00ffff00,
        32'h00fdfd00, 32'h017ffe00, 32'h00818100, 32'h01408000,
        32'h02208020, 32'h00010120, 32'h00050520, 32'h02100510,
        32'h01020410, 32'h02000400};

    vsmc_top #(.SLAVE_ID(SID)) u_vsmc_top (.clk(clk), .rst(rst),
        .sclk_i(sclk), .sdata_i(sdata), .sdata_o(sdata_o),
        .sdata_oe(sdata_oe), .vout_target(vout_target),
        .mode_auto_pfm(mode_auto_pfm), .forced_bypass(forced_bypass),
        .converter_en(converter_en), .power_state(power_state),
        .bus_ready(bus_ready));
    vsmc_master u_vsmc_master (.clk(clk), .sdata_o(sdata_o),
        .sdata_oe(sdata_oe), .sclk(sclk), .sdata(sdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        u_vsmc_master.read(a, q);
        chk(q[8:1], exp);
        chk({7'h00, q[0]}, {7'h00, ~^exp});
    endtask
    task automatic outs_chk(input logic [7:0] sp, input logic [7:0] cfg);
        vsmc_pstate_t ps;
        ps = (sp[7:1] == SP_LOW_POWER) ? PS_LOW_POWER :
             (sp[7:1] == SP_STANDBY) ? PS_STANDBY : PS_ACTIVE;
        chk(vout_target, sp);
        chk({7'h00, mode_auto_pfm}, {7'h00, cfg[5]});
        chk({7'h00, forced_bypass},
            {7'h00, cfg[4] | (sp[7:1] == SP_BYPASS)});
        chk({6'h00, power_state}, {6'h00, ps});
        chk({7'h00, converter_en}, {7'h00, ps == PS_ACTIVE});
    endtask
    task automatic all_chk(input logic [7:0] sp, input logic [7:0] cfg);
        outs_chk(sp, cfg);
        rd_chk(ADDR_FINE, sp);
        rd_chk(ADDR_COARSE, {1'b0, sp[7:1]});
        rd_chk(ADDR_CONFIG, cfg);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (bus_ready !== 1'b1 && n < SETUP_CYC) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, bus_ready}, 8'h01);
        if (bus_ready !== 1'b1)
            stop_test();
        // Let the pin synchronisers settle before the first start
        repeat (8) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        n_errors = 0;
        checks_done = 0;
        u_vsmc_master.sid = SID;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        wait_ready();
        all_chk(8'h00, 8'h00);
        foreach (rows[i]) begin
            case (rows[i][31:24])
                8'h00: u_vsmc_master.write(ADDR_FINE, rows[i][23:16]);
                8'h01: u_vsmc_master.coarse(rows[i][22:16]);
                default: u_vsmc_master.write(ADDR_CONFIG, rows[i][23:16]);
            endcase
            all_chk(rows[i][15:8], rows[i][7:0]);
        end
        // Foreign slave id and an unmapped address must change nothing
        u_vsmc_master.sid = SID ^ 4'h1;
        u_vsmc_master.write(ADDR_FINE, 8'h33);
        u_vsmc_master.sid = SID;
        u_vsmc_master.write(5'h02, 8'h77);
        rd_chk(5'h02, 8'h00);
        all_chk(8'h04, 8'h00);
        // Supply loss in mid-run: everything back to power-up values
        u_vsmc_master.write(ADDR_FINE, 8'hc0);
        u_vsmc_master.write(ADDR_CONFIG, 8'h30);
        outs_chk(8'hc0, 8'h30);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        outs_chk(8'h00, 8'h00);
        rst = 1'b0;
        wait_ready();
        all_chk(8'h00, 8'h00);
        stop_test();
    end
endmodule
